// *** verilog/umr_pkg.sv ***
// shared constants for the uart bus, reset and power control block
package umr_pkg;
  // host register addresses on the 3-bit address bus
  localparam logic [2:0] ADR_DATA = 3'h0;
  localparam logic [2:0] ADR_TRIG = 3'h1;
  localparam logic [2:0] ADR_DIVL = 3'h2;
  localparam logic [2:0] ADR_DIVH = 3'h3;
  localparam logic [2:0] ADR_FRAC = 3'h4;
  localparam logic [2:0] ADR_STAT = 3'h5;
  localparam logic [2:0] ADR_FCTL = 3'h7;
  // feature_control_reg fields
  localparam int FCTL_HALF = 3;
  localparam int FCTL_SWFLOW = 4;
  localparam int FCTL_PRE4 = 5;
  // status register fields
  localparam int ST_RXVALID = 0;
  localparam int ST_TXFULL = 1;
  localparam int ST_TXIDLE = 2;
  localparam int ST_RXTRIG = 3;
  localparam int ST_TXLOW = 4;
  localparam int ST_STOPPED = 5;
  localparam int ST_ASLEEP = 6;
  localparam int ST_HALF = 7;
  // reset values
  localparam logic [7:0] TRIG_RST = 8'h84;
  localparam logic [7:0] DIVL_RST = 8'h01;
  localparam logic [7:0] DIVH_RST = 8'h00;
  localparam logic [3:0] FRAC_RST = 4'h0;
  localparam logic [7:0] FCTL_RST = 8'h00;
  // in-band flow control characters
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  // fifo geometry
  localparam int FIFO_AW = 6;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  // oversampling points
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// *** verilog/umr_fifo_if.sv ***
// handshake bundle between a byte fifo and its user
`timescale 1ns/1ps
interface umr_fifo_if;
  logic push_valid; // writer offers a byte
  logic push_ready; // fifo has room
  logic [7:0] push_data;
  logic pop_valid; // pop_data holds the head byte
  logic pop_ready; // reader takes the head byte
  logic [7:0] pop_data;
  logic [6:0] level; // bytes stored
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, level);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data, level);
endinterface

// *** verilog/umr_fifo.sv ***
// 64-byte fifo with registered read data
`timescale 1ns/1ps
module umr_fifo (
  // clock and clear
  input wire logic clk_sys_i,
  input wire logic clear_i,
  // user side
  umr_fifo_if.store port
);
  logic [7:0] mem [0:63]; // storage, no reset needed
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic [6:0] level;
  logic settled; // head byte in pop_data is current
  logic [7:0] head;
  logic [5:0] next_wr_ptr;
  logic [5:0] next_rd_ptr;
  logic [6:0] next_level;
  logic next_settled;
  logic push_fire;
  logic pop_fire;

  // handshakes; valid waits one cycle after any move so the head is fresh
  assign port.push_ready = (level != umr_pkg::FIFO_DEPTH);
  assign port.pop_valid = (level != 7'h00) && settled;
  assign port.pop_data = head;
  assign port.level = level;
  assign push_fire = port.push_valid && port.push_ready;
  assign pop_fire = port.pop_valid && port.pop_ready;

  // pointer and level arithmetic
  always_comb
  begin
    next_wr_ptr = push_fire ? wr_ptr + 6'h01 : wr_ptr;
    next_rd_ptr = pop_fire ? rd_ptr + 6'h01 : rd_ptr;
    next_level = level + {6'h00, push_fire} - {6'h00, pop_fire};
    next_settled = !(push_fire || pop_fire);
  end

  // storage and pointer registers
  always_ff @(posedge clk_sys_i)
  begin
    if (push_fire)
    begin
      mem[wr_ptr] <= port.push_data;
    end
    head <= mem[rd_ptr];
    if (clear_i)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      level <= 7'h00;
      settled <= 1'b0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
      settled <= next_settled;
    end
  end
endmodule

// *** verilog/umr_uart.sv ***
// uart core with host bus style, reset polarity and power control
`timescale 1ns/1ps
// Notes on behaviour
// (R1) isolation during sleep freezes host bus sampling
// (R2) pump off only when asleep, clock low
// (R3) bus style pin picks strobe or direction protocol
// (R4) reset pin polarity follows bus style
// (R5) reset returns registers and outputs to defaults
// (R6) in reset: tx high, rx ignored
// (R7) direction mode ignores the read strobe
// (R8) separate 64-byte transmit and receive fifos
// (R9) xon/xoff flow control and fifo trigger levels
// (R10) fractional divisor with prescale 1 or 4
// (R11) host drives direction high read, low write
// (R12) host asserts chip select for every access
// (R13) duplex strap caught once, control bit overrides
// (R14) isolated bus: no register writes, no drive
module umr_uart (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reset_pin_i,
  // host bus
  input wire logic bus_mode_i,
  input wire logic cs_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  // power and mode pins
  input wire logic bus_isolate_request_i,
  input wire logic pump_autosleep_i,
  input wire logic sleep_request_i,
  input wire logic duplex_strap_i,
  output logic osc_buffered_out_o,
  output logic pump_off_o,
  output logic half_duplex_o,
  // serial line
  input wire logic rx_i,
  output logic tx_o,
  output logic driver_en_o
);
  typedef enum logic [1:0] {UMR_IDLE, UMR_START, UMR_DATA, UMR_STOP} umr_ser_t;

  // fifo level at or above a trigger given in units of four bytes
  function automatic logic lvl_at(input logic [6:0] lvl, input logic [3:0] trig);
    lvl_at = (lvl >= {1'b0, trig, 2'b00});
  endfunction

  umr_fifo_if tx_q (); // host to line
  umr_fifo_if rx_q (); // line to host
  logic urst; // uart reset from either source
  // bus group
  logic cs_n_q, rd_n_q, wr_n_q, isolate;
  logic [7:0] trig, divl, divh, fctl;
  logic [3:0] frac;
  logic strapped; // duplex strap already caught
  logic next_cs_n_q, next_rd_n_q, next_wr_n_q, next_isolate, next_strapped;
  logic [7:0] next_trig, next_divl, next_divh, next_fctl, next_data_o;
  logic [3:0] next_frac;
  logic next_data_oe, rd_start, rd_active, wr_commit;
  logic [7:0] status;
  // baud group
  logic [1:0] pre_cnt, next_pre_cnt;
  logic [15:0] div_cnt, next_div_cnt;
  logic [3:0] acc, next_acc;
  logic tick, next_tick;
  // transmit group
  umr_ser_t tx_st, next_tx_st;
  logic [3:0] tx_os, next_tx_os;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_sh, next_tx_sh;
  logic xoff_sent, next_xoff_sent, next_tx_o, next_driver_en;
  // receive group
  umr_ser_t rx_st, next_rx_st;
  logic [3:0] rx_os, next_rx_os;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic stopped, next_stopped;
  // power group
  logic asleep, next_osc, next_pump_off;

  // reset pin is active high in strobe mode, active low otherwise [R4]
  assign urst = !nrst_i || (bus_mode_i ? reset_pin_i : !reset_pin_i);

  umr_fifo u_txf (.clk_sys_i(clk_sys_i), .clear_i(urst), .port(tx_q.store)); // [R8]
  umr_fifo u_rxf (.clk_sys_i(clk_sys_i), .clear_i(urst), .port(rx_q.store)); // [R8]

  // sleep holds only when both engines and the transmit fifo are quiet
  assign asleep = sleep_request_i && (tx_st == UMR_IDLE) && (rx_st == UMR_IDLE)
                  && (tx_q.level == 7'h00);
  assign status = {half_duplex_o, asleep, stopped,
                   !lvl_at(tx_q.level, trig[3:0]), lvl_at(rx_q.level, trig[7:4]),
                   tx_st == UMR_IDLE, !tx_q.push_ready, rx_q.pop_valid}; // [R9]

  // host bus decode and register writes
  always_comb
  begin
    // frozen samples while isolated, so host toggling moves nothing inside
    next_cs_n_q = isolate ? cs_n_q : cs_n_i; // [R1]
    next_rd_n_q = isolate ? rd_n_q : read_strobe_n_i; // [R1]
    next_wr_n_q = isolate ? wr_n_q : write_strobe_n_i; // [R1]
    if (bus_mode_i)
    begin
      // strobe mode: read on falling read strobe, write on rising write strobe [R3]
      rd_active = !cs_n_i && !read_strobe_n_i;
      rd_start = rd_active && rd_n_q;
      wr_commit = !cs_n_i && !wr_n_q && write_strobe_n_i;
    end
    else
    begin
      // direction mode: read strobe pin unused; write line is direction [R3] [R7]
      rd_active = !cs_n_i && write_strobe_n_i; // [R11]
      rd_start = rd_active && cs_n_q;
      wr_commit = cs_n_i && !cs_n_q && !wr_n_q; // [R12]
    end
    rd_active = rd_active && !isolate; // [R14]
    rd_start = rd_start && !isolate; // [R14]
    wr_commit = wr_commit && !isolate; // [R14]
    next_trig = trig;
    next_divl = divl;
    next_divh = divh;
    next_frac = frac;
    next_fctl = fctl;
    next_strapped = 1'b1;
    tx_q.push_valid = wr_commit && (addr_i == umr_pkg::ADR_DATA);
    tx_q.push_data = data_i;
    rx_q.pop_ready = rd_start && (addr_i == umr_pkg::ADR_DATA);
    if (wr_commit)
    begin
      case (addr_i)
        umr_pkg::ADR_TRIG: next_trig = data_i; // [R9]
        umr_pkg::ADR_DIVL: next_divl = data_i; // [R10]
        umr_pkg::ADR_DIVH: next_divh = data_i; // [R10]
        umr_pkg::ADR_FRAC: next_frac = data_i[3:0]; // [R10]
        umr_pkg::ADR_FCTL: next_fctl = data_i; // [R13]
        default: next_fctl = fctl;
      endcase
    end
    // duplex strap caught on the first cycle out of power-up reset [R13]
    if (!strapped)
    begin
      next_fctl[umr_pkg::FCTL_HALF] = duplex_strap_i; // [R13]
    end
    // read data is latched at the start of the read and held
    next_data_o = data_o;
    if (rd_start)
    begin
      case (addr_i)
        umr_pkg::ADR_DATA: next_data_o = rx_q.pop_valid ? rx_q.pop_data : 8'h00;
        umr_pkg::ADR_TRIG: next_data_o = trig;
        umr_pkg::ADR_DIVL: next_data_o = divl;
        umr_pkg::ADR_DIVH: next_data_o = divh;
        umr_pkg::ADR_FRAC: next_data_o = {4'h0, frac};
        umr_pkg::ADR_STAT: next_data_o = status;
        umr_pkg::ADR_FCTL: next_data_o = fctl;
        default: next_data_o = 8'h00;
      endcase
    end
    next_data_oe = rd_active; // [R14]
    next_isolate = bus_isolate_request_i && asleep; // [R1]
  end

  // baud tick: prescaler, then divisor stretched by the fraction carry
  always_comb
  begin
    next_pre_cnt = pre_cnt + 2'h1;
    next_div_cnt = div_cnt;
    next_acc = acc;
    next_tick = 1'b0;
    if (!fctl[umr_pkg::FCTL_PRE4] || (pre_cnt == umr_pkg::PRE4_LAST)) // [R10]
    begin
      if (div_cnt == 16'h0000)
      begin
        next_tick = 1'b1;
        // carry out of the sixteenths adds one reference period [R10]
        {next_div_cnt, next_acc} = {{divh, divl} - 16'h0001, 4'h0}
                                   + {15'h0000, {1'b0, acc} + {1'b0, frac}};
        if ({divh, divl} == 16'h0000)
        begin
          next_div_cnt = 16'h0000; // zero divisor runs at full rate
        end
      end
      else
      begin
        next_div_cnt = div_cnt - 16'h0001;
      end
    end
  end

  // transmitter with in-band flow characters ahead of queued data
  always_comb
  begin
    next_tx_st = tx_st;
    next_tx_os = tx_os;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_xoff_sent = xoff_sent;
    next_tx_o = 1'b1;
    tx_q.pop_ready = 1'b0;
    case (tx_st)
      UMR_IDLE:
      begin
        if (fctl[umr_pkg::FCTL_SWFLOW] && !xoff_sent && lvl_at(rx_q.level, trig[7:4]))
        begin
          next_tx_sh = umr_pkg::XOFF_CHAR; // receiver near full [R9]
          next_xoff_sent = 1'b1;
          next_tx_st = UMR_START;
        end
        else if (xoff_sent && !lvl_at(rx_q.level, trig[7:4]))
        begin
          next_tx_sh = umr_pkg::XON_CHAR; // room again, resume far end [R9]
          next_xoff_sent = 1'b0;
          next_tx_st = UMR_START;
        end
        else if (tx_q.pop_valid && !stopped) // [R9]
        begin
          tx_q.pop_ready = 1'b1;
          next_tx_sh = tx_q.pop_data;
          next_tx_st = UMR_START;
        end
        next_tx_os = 4'h0;
        next_tx_bit = 3'h0;
      end
      UMR_START:
      begin
        next_tx_o = 1'b0;
        if (tick)
        begin
          next_tx_os = tx_os + 4'h1;
          next_tx_st = (tx_os == umr_pkg::OS_LAST) ? UMR_DATA : UMR_START;
        end
      end
      UMR_DATA:
      begin
        next_tx_o = tx_sh[0];
        if (tick)
        begin
          next_tx_os = tx_os + 4'h1;
          if (tx_os == umr_pkg::OS_LAST)
          begin
            next_tx_sh = {1'b0, tx_sh[7:1]};
            next_tx_o = tx_sh[1];
            next_tx_bit = tx_bit + 3'h1;
            next_tx_st = (tx_bit == umr_pkg::BIT_LAST) ? UMR_STOP : UMR_DATA;
            next_tx_o = (tx_bit == umr_pkg::BIT_LAST) ? 1'b1 : tx_sh[1];
          end
        end
      end
      UMR_STOP:
      begin
        if (tick)
        begin
          next_tx_os = tx_os + 4'h1;
          next_tx_st = (tx_os == umr_pkg::OS_LAST) ? UMR_IDLE : UMR_STOP;
        end
      end
      default: next_tx_st = UMR_IDLE;
    endcase
    if (next_tx_st == UMR_START)
    begin
      next_tx_o = 1'b0;
    end
    // half duplex drives the line only while a frame is going out
    next_driver_en = !fctl[umr_pkg::FCTL_HALF] || (next_tx_st != UMR_IDLE);
  end

  // receiver, deaf to its own echo in half duplex
  always_comb
  begin
    next_rx_st = rx_st;
    next_rx_os = rx_os;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_stopped = stopped && fctl[umr_pkg::FCTL_SWFLOW];
    rx_q.push_valid = 1'b0;
    rx_q.push_data = rx_sh;
    case (rx_st)
      UMR_IDLE:
      begin
        next_rx_os = 4'h0;
        next_rx_bit = 3'h0;
        if (!rx_i && !(fctl[umr_pkg::FCTL_HALF] && tx_st != UMR_IDLE))
        begin
          next_rx_st = UMR_START;
        end
      end
      UMR_START:
      begin
        if (tick)
        begin
          next_rx_os = rx_os + 4'h1;
          if (rx_os == umr_pkg::OS_MID)
          begin
            // realign to mid bit; a short glitch is dropped
            next_rx_os = 4'h0;
            next_rx_st = rx_i ? UMR_IDLE : UMR_DATA;
          end
        end
      end
      UMR_DATA:
      begin
        if (tick)
        begin
          next_rx_os = rx_os + 4'h1;
          if (rx_os == umr_pkg::OS_LAST)
          begin
            next_rx_sh = {rx_i, rx_sh[7:1]};
            next_rx_bit = rx_bit + 3'h1;
            next_rx_st = (rx_bit == umr_pkg::BIT_LAST) ? UMR_STOP : UMR_DATA;
          end
        end
      end
      UMR_STOP:
      begin
        if (tick)
        begin
          next_rx_os = rx_os + 4'h1;
          if (rx_os == umr_pkg::OS_LAST)
          begin
            next_rx_st = UMR_IDLE;
            if (rx_i && fctl[umr_pkg::FCTL_SWFLOW] && (rx_sh == umr_pkg::XOFF_CHAR))
            begin
              next_stopped = 1'b1; // far end asks us to pause [R9]
            end
            else if (rx_i && fctl[umr_pkg::FCTL_SWFLOW] && (rx_sh == umr_pkg::XON_CHAR))
            begin
              next_stopped = 1'b0; // [R9]
            end
            else
            begin
              rx_q.push_valid = rx_i; // full fifo drops the byte
            end
          end
        end
      end
      default: next_rx_st = UMR_IDLE;
    endcase
  end

  // oscillator follower and charge pump control
  always_comb
  begin
    next_osc = !asleep && !osc_buffered_out_o;
    next_pump_off = pump_autosleep_i && asleep && !osc_buffered_out_o; // [R2]
  end

  // all state registers; reset holds tx high and idles the receiver
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      strapped <= 1'b0;
    end
    else
    begin
      strapped <= next_strapped;
    end
    if (urst) // [R5] [R6]
    begin
      {cs_n_q, rd_n_q, wr_n_q} <= 3'h7;
      isolate <= 1'b0;
      trig <= umr_pkg::TRIG_RST;
      divl <= umr_pkg::DIVL_RST;
      divh <= umr_pkg::DIVH_RST;
      frac <= umr_pkg::FRAC_RST;
      fctl <= umr_pkg::FCTL_RST;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      {pre_cnt, div_cnt, acc, tick} <= 23'h000000;
      tx_st <= UMR_IDLE;
      {tx_os, tx_bit, tx_sh, xoff_sent} <= 16'h0000;
      tx_o <= 1'b1; // [R6]
      driver_en_o <= 1'b0;
      rx_st <= UMR_IDLE; // [R6]
      {rx_os, rx_bit, rx_sh, stopped} <= 16'h0000;
      osc_buffered_out_o <= 1'b0;
      pump_off_o <= 1'b0;
      half_duplex_o <= 1'b0;
    end
    else
    begin
      {cs_n_q, rd_n_q, wr_n_q} <= {next_cs_n_q, next_rd_n_q, next_wr_n_q};
      isolate <= next_isolate;
      trig <= next_trig;
      divl <= next_divl;
      divh <= next_divh;
      frac <= next_frac;
      fctl <= strapped ? next_fctl : {next_fctl[7:4], duplex_strap_i, next_fctl[2:0]};
      data_o <= next_data_o;
      data_oe_o <= next_data_oe;
      {pre_cnt, div_cnt, acc, tick} <= {next_pre_cnt, next_div_cnt, next_acc, next_tick};
      tx_st <= next_tx_st;
      {tx_os, tx_bit, tx_sh, xoff_sent} <= {next_tx_os, next_tx_bit, next_tx_sh, next_xoff_sent};
      tx_o <= next_tx_o;
      driver_en_o <= next_driver_en;
      rx_st <= next_rx_st;
      {rx_os, rx_bit, rx_sh, stopped} <= {next_rx_os, next_rx_bit, next_rx_sh, next_stopped};
      osc_buffered_out_o <= next_osc;
      pump_off_o <= next_pump_off;
      half_duplex_o <= next_fctl[umr_pkg::FCTL_HALF];
    end
  end
endmodule

// *** tb/umr_host_bfm.sv ***
// host processor model for the strobe and direction bus styles
`timescale 1ns/1ps
module umr_host_bfm (
  // clock and bus style
  input wire logic clk_sys_i,
  input wire logic bus_mode_i,
  // bus toward the device
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o
);
  // idle bus at time zero
  initial
  begin
    cs_n_o = 1'b1;
    addr_o = 3'h0;
    wdata_o = 8'h00;
    read_strobe_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
  end
  // one access; the committing line (strobe, or select in direction style) held three edges, the rest four, gap of two
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    addr_o <= a;
    wdata_o <= d;
    write_strobe_n_o <= ~wr;
    // direction style: read strobe held low to show it is unused
    read_strobe_n_o <= bus_mode_i ? wr : 1'b0;
    repeat (3) @(posedge clk_sys_i);
    q = rdata_i;
    // strobe style commits on strobe rise, direction style on select rise
    if (bus_mode_i)
    begin
      write_strobe_n_o <= 1'b1;
      read_strobe_n_o <= 1'b1;
    end
    else
      cs_n_o <= 1'b1;
    @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
    read_strobe_n_o <= 1'b1;
    // released data lines show the inverse, not a stale copy
    wdata_o <= ~d;
    repeat (2) @(posedge clk_sys_i);
  endtask
endmodule

// *** tb/umr_uart_chk.sv ***
// pin-level assertions for the uart bus, reset and power block
`timescale 1ns/1ps
module umr_uart_chk (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reset_pin_i,
  // host bus
  input wire logic bus_mode_i,
  input wire logic cs_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic data_oe_o,
  // power, mode and line
  input wire logic bus_isolate_request_i,
  input wire logic pump_autosleep_i,
  input wire logic sleep_request_i,
  input wire logic duplex_strap_i,
  input wire logic osc_buffered_out_o,
  input wire logic pump_off_o,
  input wire logic half_duplex_o,
  input wire logic tx_o,
  input wire logic driver_en_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // pin reset is active when its level equals the bus style
  logic pin_rst;
  assign pin_rst = (reset_pin_i == bus_mode_i);
  AST_TX_RST: assert property (pin_rst |=> tx_o && !driver_en_o && !data_oe_o)
    else $error("line or bus not idle during reset");
  AST_PUMP: assert property (pump_off_o |-> !osc_buffered_out_o && $past(pump_autosleep_i))
    else $error("pump off without autosleep while asleep");
  AST_OSC_RUN: assert property ((!sleep_request_i && !pin_rst) [*3] |->
    osc_buffered_out_o != $past(osc_buffered_out_o))
    else $error("buffered clock stopped while awake");
  AST_ISO: assert property ((bus_isolate_request_i && !osc_buffered_out_o) [*3] |-> !data_oe_o)
    else $error("data bus driven while isolated");
  AST_RD_STB: assert property (bus_mode_i && !pin_rst && !bus_isolate_request_i && !cs_n_i
    && !$past(bus_isolate_request_i) // isolation is registered, so it lingers one cycle
    && !read_strobe_n_i && $past(read_strobe_n_i) |=> data_oe_o)
    else $error("strobe read not answered");
  AST_RD_DIR: assert property (!bus_mode_i && !pin_rst && !bus_isolate_request_i && !cs_n_i
    && !$past(bus_isolate_request_i) // same one-cycle lag as the strobe style
    && $past(cs_n_i) && write_strobe_n_i |=> data_oe_o)
    else $error("direction read not answered");
  AST_DIR_WR: assert property ((!bus_mode_i && !cs_n_i && !write_strobe_n_i) [*2] |-> !data_oe_o)
    else $error("read strobe honoured in direction style");
  AST_STRAP: assert property ($rose(nrst_i) |-> ##2 half_duplex_o == duplex_strap_i)
    else $error("duplex strap not captured");
  AST_FULL_DRV: assert property ((!half_duplex_o && !pin_rst) [*3] |-> driver_en_o)
    else $error("driver off in full duplex");
endmodule
bind umr_uart umr_uart_chk chk (.clk_sys_i, .nrst_i, .reset_pin_i, .bus_mode_i, .cs_n_i,
  .read_strobe_n_i, .write_strobe_n_i, .data_oe_o, .bus_isolate_request_i, .pump_autosleep_i,
  .sleep_request_i, .duplex_strap_i, .osc_buffered_out_o, .pump_off_o, .half_duplex_o, .tx_o,
  .driver_en_o);

// *** tb/tb.sv ***
// self-checking bench for the uart bus, reset and power block
`timescale 1ns/1ps
module tb;
  // pins
  logic clk_sys_i, nrst_i, reset_pin_i, bus_mode_i;
  logic iso, pump, slp, strap;
  logic cs_n, rs_n, ws_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, q;
  logic oe, osc, pump_off, half, tx, drv;
  wire [7:0] bus;
  int errors, checks;
  // 200 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // shared data wire: device wins while it drives
  assign bus = oe ? rdata : wdata;
  umr_host_bfm host (.clk_sys_i, .bus_mode_i, .rdata_i(rdata), .cs_n_o(cs_n), .addr_o(addr),
    .wdata_o(wdata), .read_strobe_n_o(rs_n), .write_strobe_n_o(ws_n));
  // serial line looped back so each sent byte returns
  umr_uart dut (.clk_sys_i, .nrst_i, .reset_pin_i, .bus_mode_i, .cs_n_i(cs_n), .addr_i(addr),
    .data_i(bus), .data_o(rdata), .data_oe_o(oe), .read_strobe_n_i(rs_n),
    .write_strobe_n_i(ws_n), .bus_isolate_request_i(iso), .pump_autosleep_i(pump),
    .sleep_request_i(slp), .duplex_strap_i(strap), .osc_buffered_out_o(osc),
    .pump_off_o(pump_off), .half_duplex_o(half), .rx_i(tx), .tx_o(tx), .driver_en_o(drv));
  // byte compare
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    host.access(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask
  // power-up reset with a bus style and strap
  task automatic por(input logic mode, input logic s);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    bus_mode_i <= mode;
    reset_pin_i <= ~mode;
    strap <= s;
    repeat (5) @(posedge clk_sys_i);
    chk("tx in reset", 8'h01, {7'h0, tx});
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
  endtask
  // 40 ns pulse on the reset pin, polarity from bus style
  task automatic pin_pulse();
    @(posedge clk_sys_i);
    reset_pin_i <= bus_mode_i;
    repeat (8) @(posedge clk_sys_i);
    chk("tx in pin reset", 8'h01, {7'h0, tx});
    reset_pin_i <= ~bus_mode_i;
    repeat (2) @(posedge clk_sys_i);
  endtask
  // send a byte, poll status until it returns, then read it
  task automatic echo(input logic [7:0] d);
    logic [7:0] st;
    st = 8'h00;
    wr(umr_pkg::ADR_DATA, d);
    for (int i = 0; i < 200 && st[umr_pkg::ST_RXVALID] !== 1'b1; i++)
      host.access(1'b0, umr_pkg::ADR_STAT, 8'h00, st);
    rd(umr_pkg::ADR_DATA, d, "looped byte");
  endtask
  task automatic results();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial
  begin
    repeat (30000) @(posedge clk_sys_i);
    errors++;
    results();
  end
  // main sequence
  initial
  begin
    errors = 0;
    checks = 0;
    {nrst_i, reset_pin_i, bus_mode_i, iso, pump, slp, strap} = 7'h04;
    por(1'b1, 1'b1);
    chk("strap half", 8'h01, {7'h0, half});
    rd(umr_pkg::ADR_TRIG, umr_pkg::TRIG_RST, "trigger reset");
    rd(umr_pkg::ADR_DIVH, umr_pkg::DIVH_RST, "divisor high reset");
    rd(umr_pkg::ADR_FCTL, 8'h08, "control with strap");
    wr(umr_pkg::ADR_FCTL, 8'h00);
    chk("half cleared", 8'h00, {7'h0, half});
    wr(umr_pkg::ADR_FCTL, 8'h20);
    wr(umr_pkg::ADR_FRAC, 8'h08);
    echo(8'h3c);
    wr(umr_pkg::ADR_FCTL, 8'h00);
    wr(umr_pkg::ADR_FRAC, 8'h00);
    echo(8'ha5);
    wr(umr_pkg::ADR_TRIG, 8'h21);
    rd(umr_pkg::ADR_TRIG, 8'h21, "trigger");
    // received xon is swallowed when flow control is on
    wr(umr_pkg::ADR_FCTL, 8'h10);
    wr(umr_pkg::ADR_DATA, umr_pkg::XON_CHAR);
    repeat (400) @(posedge clk_sys_i);
    rd(umr_pkg::ADR_STAT, 8'h14, "status after xon");
    wr(umr_pkg::ADR_FCTL, 8'h00);
    // sleep, pump autosleep, then isolation
    slp <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk("clock out asleep", 8'h00, {7'h0, osc});
    rd(umr_pkg::ADR_STAT, 8'h54, "asleep status");
    pump <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("pump off", 8'h01, {7'h0, pump_off});
    iso <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    wr(umr_pkg::ADR_DIVL, 8'h55);
    // an isolated read must not start: data_o keeps the asleep status
    rd(umr_pkg::ADR_DIVL, 8'h54, "no read while isolated");
    pump <= 1'b0;
    iso <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    slp <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd(umr_pkg::ADR_DIVL, umr_pkg::DIVL_RST, "divisor after isolation");
    wr(umr_pkg::ADR_DIVL, 8'h07);
    // frame in flight when the pin reset hits, so a held-high line means something
    wr(umr_pkg::ADR_DATA, 8'h00);
    pin_pulse();
    rd(umr_pkg::ADR_DIVL, umr_pkg::DIVL_RST, "divisor after pin reset");
    // direction style bus
    por(1'b0, 1'b0);
    wr(umr_pkg::ADR_DIVL, 8'h33);
    rd(umr_pkg::ADR_DIVL, 8'h33, "direction write");
    // back to full rate, else the frame outlasts the status poll
    wr(umr_pkg::ADR_DIVL, umr_pkg::DIVL_RST);
    echo(8'h5a);
    wr(umr_pkg::ADR_DIVL, 8'h33);
    pin_pulse();
    rd(umr_pkg::ADR_DIVL, umr_pkg::DIVL_RST, "divisor after low pin reset");
    results();
  end
endmodule
